// *** hw/tcc_pkg.sv ***
// Package: register map, field positions and codes of the timer clock front end
package tcc_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CMD_OFFSET      = 8'h00;
	localparam logic [7:0] MODE_OFFSET     = 8'h04;
	localparam logic [7:0] COUNTER_OFFSET  = 8'h10;
	localparam logic [7:0] CAPA_OFFSET     = 8'h14;
	localparam logic [7:0] CAPB_OFFSET     = 8'h18;
	localparam logic [7:0] CMPC_OFFSET     = 8'h1c;
	localparam logic [7:0] STATUS_OFFSET   = 8'h20;
	localparam logic [7:0] ROUTING_OFFSET  = 8'hc4;

	// ----------------------------------------
	// Command register bits
	// ----------------------------------------
	localparam int CMD_ENABLE_BIT  = 0;
	localparam int CMD_DISABLE_BIT = 1;
	localparam int CMD_TRIGGER_BIT = 2;

	// ----------------------------------------
	// Mode register fields (capture layout)
	// ----------------------------------------
	localparam int MODE_CLKSEL_LSB   = 0;
	localparam int MODE_INVERT_BIT   = 3;
	localparam int MODE_GATE_LSB     = 4;
	localparam int MODE_BSTOP_BIT    = 6;
	localparam int MODE_BDIS_BIT     = 7;
	localparam int MODE_TRIGEDGE_LSB = 8;
	localparam int MODE_TRIGPIN_BIT  = 10;
	localparam int MODE_CMPTRIG_BIT  = 14;
	localparam int MODE_WAVE_BIT     = 15;
	localparam int MODE_LOADA_LSB    = 16;
	localparam int MODE_LOADB_LSB    = 18;
	localparam logic [31:0] MODE_WRITE_MASK = 32'h000f_c7ff;
	localparam logic [31:0] MODE_RESET      = 32'h0000_0000;

	// ----------------------------------------
	// Routing register fields
	// ----------------------------------------
	localparam int ROUTE_LINE0_LSB = 0;
	localparam int ROUTE_LINE1_LSB = 2;
	localparam int ROUTE_LINE2_LSB = 4;
	localparam logic [31:0] ROUTE_WRITE_MASK = 32'h0000_003f;
	localparam logic [31:0] ROUTE_RESET      = 32'h0000_0000;

	// ----------------------------------------
	// Status register bits
	// ----------------------------------------
	localparam int STAT_CLKON_BIT = 16;
	localparam int STAT_LINE0_BIT = 17;

	// ----------------------------------------
	// Prescaler: master_clock divided by 2, 8, 32, 128, 1024
	// ----------------------------------------
	localparam int PRESCALE_WIDTH = 10;
	localparam int DIV2_BIT       = 0;
	localparam int DIV8_BIT       = 2;
	localparam int DIV32_BIT      = 4;
	localparam int DIV128_BIT     = 6;
	localparam int DIV1024_BIT    = 9;

	// ----------------------------------------
	// Edge selection codes
	// ----------------------------------------
	localparam logic [1:0] EDGE_NONE    = 2'h0;
	localparam logic [1:0] EDGE_RISING  = 2'h1;
	localparam logic [1:0] EDGE_FALLING = 2'h2;
	localparam logic [1:0] EDGE_BOTH    = 2'h3;

	localparam int COUNT_WIDTH = 16;
	localparam int SYNC_STAGES = 2;

endpackage : tcc_pkg

// *** hw/tcc_sync.sv ***
// Two-flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
module tcc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} tcc_sync_state_type;

	tcc_sync_state_type state_reg;
	tcc_sync_state_type state_next;

	always_comb begin
		state_next.stage1 = asyncIn;
		state_next.stage2 = state_reg.stage1;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign syncOut = state_reg.stage2;

endmodule : tcc_sync

// *** hw/tcc_edge.sv ***
// Edge selector: one-cycle event on the chosen edge(s) of a sampled level
`timescale 1ns/1ns
module tcc_edge (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       level,
	input  wire logic [1:0] edgeSel,
	output logic            edgeHit
);

	typedef struct packed {
		logic last;
	} tcc_edge_state_type;

	tcc_edge_state_type state_reg;
	tcc_edge_state_type state_next;
	logic               rise;
	logic               fall;

	always_comb begin
		state_next.last = level;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rise = level & ~state_reg.last;
	assign fall = ~level & state_reg.last;

	always_comb begin
		case (edgeSel)
			tcc_pkg::EDGE_RISING:  edgeHit = rise;
			tcc_pkg::EDGE_FALLING: edgeHit = fall;
			tcc_pkg::EDGE_BOTH:    edgeHit = rise | fall;
			default:               edgeHit = 1'b0;
		endcase
	end

endmodule : tcc_edge

// *** hw/tcc_channel.sv ***
// Timer channel clock and command front end with capture, behind a Wishbone slave
// Functional notes
// RULE_01: Line 0 source: 00 clock pin 0, 01 none, 10 io A1, 11 io A2.
// RULE_02: Line 1 source: 00 clock pin 1, 01 none, 10 io A0, 11 io A2.
// RULE_03: Line 2 source: 00 clock pin 2, 01 none, 10 io A0, 11 io A1.
// RULE_04: Enable command starts clock unless disable written together; zero does nothing.
// RULE_05: Disable command turns the counter clock off; zero does nothing.
// RULE_06: Software trigger clears the counter and starts the clock.
// RULE_07: Clock source: master divided by 2..1024, or shared lines 0..2.
// RULE_08: Invert bit picks rising or falling edge of selected clock for counting.
// RULE_09: Gate field leaves clock ungated or ANDs it with shared line 0..2.
// RULE_10: Stop-on-B-load stops the counter clock when capture B loads.
// RULE_11: Disable-on-B-load disables the counter clock when capture B loads.
// RULE_12: Mode register uses capture layout while wave select bit 15 is zero.
// RULE_13: Capture A loads counter on none, rising, falling or each io A edge.
// RULE_14: Capture B loads counter on none, rising, falling or each io A edge.
// RULE_15: External trigger edge selectable; pin select chooses io B or io A.
// RULE_16: Compare trigger on: match with compare C clears counter, starts clock.
// RULE_17: Source mux, then gate, then edge; count only while enabled, not stopped.
// RULE_18: Disabled clock stays off until enable command or a trigger.
`timescale 1ns/1ns
module tcc_channel (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [2:0]  clkInputPin,
	input  wire logic [2:0]  ioAPin,
	input  wire logic        ioBPin,
	output logic      [15:0] counterValue,
	output logic             counterClockOn
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [31:0]                        mode;
		logic [31:0]                        routing;
		logic [31:0]                        compareC;
		logic [tcc_pkg::COUNT_WIDTH-1:0]    counter;
		logic [tcc_pkg::COUNT_WIDTH-1:0]    captureA;
		logic [tcc_pkg::COUNT_WIDTH-1:0]    captureB;
		logic [tcc_pkg::PRESCALE_WIDTH-1:0] prescale;
		logic                               clkEnabled;
		logic                               clkStopped;
		logic                               countLevel;
		logic                               ack;
		logic [31:0]                        rdata;
	} tcc_chan_state_type;

	tcc_chan_state_type state_reg;
	tcc_chan_state_type state_next;

	logic [2:0]  clkPinSync;
	logic [2:0]  ioASync;
	logic        ioBSync;
	logic [2:0]  sharedLine;
	logic        selClock;
	logic        gatedClock;
	logic        countEdge;
	logic        trigLevel;
	logic        extTrigger;
	logic        loadAEvent;
	logic        loadBEvent;
	logic        wbAccess;
	logic        wbWrite;
	logic [31:0] byteMask;
	logic [31:0] readMux;
	logic        captureMode;
	logic        compareMatch;
	logic        cmdEnable;
	logic        cmdDisable;
	logic        cmdTrigger;
	logic        anyTrigger;
	logic [1:0]  line0Sel;
	logic [1:0]  line1Sel;
	logic [1:0]  line2Sel;
	logic [2:0]  clkSel;
	logic [1:0]  gateSel;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Pins and sibling outputs are asynchronous to this clock
	tcc_sync #(
		.WIDTH(7)
	) pinSync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.asyncIn ({ioBPin, ioAPin, clkInputPin}),
		.syncOut ({ioBSync, ioASync, clkPinSync})
	);

	// ----------------------------------------
	// Shared line routing
	// ----------------------------------------
	assign line0Sel = state_reg.routing[tcc_pkg::ROUTE_LINE0_LSB +: 2];
	assign line1Sel = state_reg.routing[tcc_pkg::ROUTE_LINE1_LSB +: 2];
	assign line2Sel = state_reg.routing[tcc_pkg::ROUTE_LINE2_LSB +: 2];

	// Line code 01 leaves the line low
	always_comb begin
		case (line0Sel)
			2'h0:    sharedLine[0] = clkPinSync[0]; // RULE_01
			2'h2:    sharedLine[0] = ioASync[1];    // RULE_01
			2'h3:    sharedLine[0] = ioASync[2];    // RULE_01
			default: sharedLine[0] = 1'b0;
		endcase
		case (line1Sel)
			2'h0:    sharedLine[1] = clkPinSync[1]; // RULE_02
			2'h2:    sharedLine[1] = ioASync[0];    // RULE_02
			2'h3:    sharedLine[1] = ioASync[2];    // RULE_02
			default: sharedLine[1] = 1'b0;
		endcase
		case (line2Sel)
			2'h0:    sharedLine[2] = clkPinSync[2]; // RULE_03
			2'h2:    sharedLine[2] = ioASync[0];    // RULE_03
			2'h3:    sharedLine[2] = ioASync[1];    // RULE_03
			default: sharedLine[2] = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Clock source, gating and counting edge
	// ----------------------------------------
	assign clkSel      = state_reg.mode[tcc_pkg::MODE_CLKSEL_LSB +: 3];
	assign gateSel     = state_reg.mode[tcc_pkg::MODE_GATE_LSB +: 2];
	assign captureMode = ~state_reg.mode[tcc_pkg::MODE_WAVE_BIT]; // RULE_12

	always_comb begin
		case (clkSel)
			3'h0:    selClock = state_reg.prescale[tcc_pkg::DIV2_BIT];    // RULE_07
			3'h1:    selClock = state_reg.prescale[tcc_pkg::DIV8_BIT];    // RULE_07
			3'h2:    selClock = state_reg.prescale[tcc_pkg::DIV32_BIT];   // RULE_07
			3'h3:    selClock = state_reg.prescale[tcc_pkg::DIV128_BIT];  // RULE_07
			3'h4:    selClock = state_reg.prescale[tcc_pkg::DIV1024_BIT]; // RULE_07
			3'h5:    selClock = sharedLine[0];                           // RULE_07
			3'h6:    selClock = sharedLine[1];                           // RULE_07
			default: selClock = sharedLine[2];                           // RULE_07
		endcase
		case (gateSel)
			2'h1:    gatedClock = selClock & sharedLine[0]; // RULE_09
			2'h2:    gatedClock = selClock & sharedLine[1]; // RULE_09
			2'h3:    gatedClock = selClock & sharedLine[2]; // RULE_09
			default: gatedClock = selClock;                 // RULE_09
		endcase
	end

	// Edge taken after gating; invert bit picks the falling edge
	assign countEdge = state_reg.mode[tcc_pkg::MODE_INVERT_BIT]
		? (~gatedClock & state_reg.countLevel)   // RULE_08
		: (gatedClock & ~state_reg.countLevel);  // RULE_08 RULE_17

	// ----------------------------------------
	// Trigger edge detection
	// ----------------------------------------
	assign trigLevel = state_reg.mode[tcc_pkg::MODE_TRIGPIN_BIT] ? ioASync[0] : ioBSync; // RULE_15

	tcc_edge trigEdge (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.level   (trigLevel),
		.edgeSel (state_reg.mode[tcc_pkg::MODE_TRIGEDGE_LSB +: 2]),
		.edgeHit (extTrigger)
	);

	// ----------------------------------------
	// Capture edge detection
	// ----------------------------------------
	tcc_edge loadAEdge (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.level   (ioASync[0]),
		.edgeSel (state_reg.mode[tcc_pkg::MODE_LOADA_LSB +: 2]),
		.edgeHit (loadAEvent)
	);

	tcc_edge loadBEdge (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.level   (ioASync[0]),
		.edgeSel (state_reg.mode[tcc_pkg::MODE_LOADB_LSB +: 2]),
		.edgeHit (loadBEvent)
	);

	// ----------------------------------------
	// Wishbone decode
	// ----------------------------------------
	// Ack high blocks a second take while the master still holds stb
	assign wbAccess = wb_cyc_i & wb_stb_i & ~state_reg.ack;
	assign wbWrite  = wbAccess & wb_we_i;

	// ----------------------------------------
	// Byte lanes
	// ----------------------------------------
	generate
		for (genvar i = 0; i < 4; i++) begin : genMask
			assign byteMask[8*i +: 8] = {8{wb_sel_i[i]}};
		end
	endgenerate

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	assign cmdEnable  = wbWrite && wb_adr_i == tcc_pkg::CMD_OFFSET && wb_sel_i[0]
		&& wb_dat_i[tcc_pkg::CMD_ENABLE_BIT];
	assign cmdDisable = wbWrite && wb_adr_i == tcc_pkg::CMD_OFFSET && wb_sel_i[0]
		&& wb_dat_i[tcc_pkg::CMD_DISABLE_BIT];
	assign cmdTrigger = wbWrite && wb_adr_i == tcc_pkg::CMD_OFFSET && wb_sel_i[0]
		&& wb_dat_i[tcc_pkg::CMD_TRIGGER_BIT];

	// ----------------------------------------
	// Compare and trigger sources
	// ----------------------------------------
	// Match is judged on the counting edge, before the increment
	assign compareMatch = captureMode && countEdge && state_reg.clkEnabled
		&& !state_reg.clkStopped
		&& state_reg.counter == state_reg.compareC[tcc_pkg::COUNT_WIDTH-1:0];

	assign anyTrigger = cmdTrigger // RULE_06
		| (captureMode & extTrigger) // RULE_15
		| (compareMatch & state_reg.mode[tcc_pkg::MODE_CMPTRIG_BIT]); // RULE_16

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Write-only and unmapped offsets read as zero
	always_comb begin
		case (wb_adr_i)
			tcc_pkg::MODE_OFFSET:    readMux = state_reg.mode;
			tcc_pkg::COUNTER_OFFSET: readMux = {16'h0000, state_reg.counter};
			tcc_pkg::CAPA_OFFSET:    readMux = {16'h0000, state_reg.captureA};
			tcc_pkg::CAPB_OFFSET:    readMux = {16'h0000, state_reg.captureB};
			tcc_pkg::CMPC_OFFSET:    readMux = state_reg.compareC;
			tcc_pkg::STATUS_OFFSET:  readMux = {12'h000, sharedLine, state_reg.clkEnabled,
			                                    16'h0000};
			tcc_pkg::ROUTING_OFFSET: readMux = state_reg.routing;
			default:                 readMux = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_next            = state_reg;
		state_next.ack        = wbAccess;
		// Free-running divider; each bit is a divided master clock
		state_next.prescale   = state_reg.prescale + 1'b1;
		state_next.countLevel = gatedClock;
		// Read data is latched with the take and stands until the next access
		if (wbAccess) begin
			state_next.rdata = wb_we_i ? 32'h0000_0000 : readMux;
		end

		// Register writes
		if (wbWrite) begin
			case (wb_adr_i)
				tcc_pkg::MODE_OFFSET: begin
					state_next.mode = (state_reg.mode & ~(byteMask & tcc_pkg::MODE_WRITE_MASK))
						| (wb_dat_i & byteMask & tcc_pkg::MODE_WRITE_MASK); // RULE_12
				end
				tcc_pkg::CMPC_OFFSET: begin
					state_next.compareC = (state_reg.compareC & ~byteMask)
						| (wb_dat_i & byteMask & 32'h0000_ffff);
				end
				tcc_pkg::ROUTING_OFFSET: begin
					state_next.routing = (state_reg.routing & ~(byteMask & tcc_pkg::ROUTE_WRITE_MASK))
						| (wb_dat_i & byteMask & tcc_pkg::ROUTE_WRITE_MASK);
				end
				default: begin
				end
			endcase
		end

		// Counting only while enabled and not stopped
		if (state_reg.clkEnabled && !state_reg.clkStopped && countEdge) begin
			state_next.counter = state_reg.counter + 1'b1; // RULE_17
		end

		// Captures in capture layout only
		if (captureMode && loadAEvent) begin
			state_next.captureA = state_reg.counter; // RULE_13
		end
		// Load B stop or disable is overridden by an enable command or a trigger in the same cycle
		if (captureMode && loadBEvent) begin
			state_next.captureB = state_reg.counter; // RULE_14
			if (state_reg.mode[tcc_pkg::MODE_BSTOP_BIT]) begin
				state_next.clkStopped = 1'b1; // RULE_10
			end
			if (state_reg.mode[tcc_pkg::MODE_BDIS_BIT]) begin
				state_next.clkEnabled = 1'b0; // RULE_11 RULE_18
			end
		end

		// Enable command restarts; disable wins over enable
		if (cmdEnable && !cmdDisable) begin
			state_next.clkEnabled = 1'b1; // RULE_04 RULE_18
			state_next.clkStopped = 1'b0;
		end

		// Trigger clears counter and starts the clock
		if (anyTrigger) begin
			state_next.counter    = '0;   // RULE_06 RULE_16
			state_next.clkEnabled = 1'b1; // RULE_18
			state_next.clkStopped = 1'b0;
		end

		if (cmdDisable) begin
			state_next.clkEnabled = 1'b0; // RULE_05
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg         <= '0;
			state_reg.mode    <= tcc_pkg::MODE_RESET;
			state_reg.routing <= tcc_pkg::ROUTE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_ack_o       = state_reg.ack;
	assign wb_dat_o       = state_reg.rdata;
	assign counterValue   = state_reg.counter;
	assign counterClockOn = state_reg.clkEnabled & ~state_reg.clkStopped;

endmodule : tcc_channel

// *** testbench/tcc_pins_model.sv ***
// Far-side model of the clock pins and io A pins of the three channels
`timescale 1ns/1ns
module tcc_pins_model #(
	parameter int HALF = 8
) (
	input  wire logic       sys_clk,
	input  wire logic       run,
	input  wire logic       lvl,
	input  wire logic [2:0] src,
	output logic      [2:0] clkInputPin,
	output logic      [2:0] ioAPin
);
	logic [7:0] cnt = 8'h00;
	logic       tog = 1'b0;
	logic [5:0] pins;

	always @(posedge sys_clk) begin
		cnt <= (cnt == HALF - 1) ? 8'h00 : cnt + 8'h01;
		if (cnt == HALF - 1)
			tog <= ~tog;
	end

	// Unselected lines rest low; the selected one toggles or follows lvl
	always_comb begin
		pins = 6'h00;
		if (src < 3'h6)
			pins[src] = run ? tog : lvl;
	end

	assign clkInputPin = pins[2:0];
	assign ioAPin      = pins[5:3];
endmodule : tcc_pins_model

// *** testbench/tcc_channel_asserts.sv ***
// Checker of the bus handshake and the counter clock commands
`timescale 1ns/1ns
module tcc_channel_asserts (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [15:0] counterValue,
	input wire logic        counterClockOn
);
	logic taken;
	logic cmdWr;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign cmdWr = taken && wb_we_i && wb_sel_i[0] && wb_adr_i == tcc_pkg::CMD_OFFSET;

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_latency: assert property (taken |=> wb_ack_o)
		else $error("ack missing after request");
	a_enable_cmd: assert property (cmdWr && wb_dat_i[1:0] == 2'h1 |=> counterClockOn)
		else $error("enable command ignored");
	a_disable_cmd: assert property (cmdWr && wb_dat_i[1] |=> !counterClockOn)
		else $error("disable command ignored");
	a_soft_trig: assert property (cmdWr && wb_dat_i[2:1] == 2'h2 |=>
		counterClockOn && counterValue == 16'h0000)
		else $error("software trigger failed");
	a_count_step: assert property ($changed(counterValue) |->
		counterValue == $past(counterValue) + 16'h0001 || counterValue == 16'h0000)
		else $error("counter jumped");
	a_off_hold: assert property (!counterClockOn && !cmdWr |=>
		$stable(counterValue) || counterValue == 16'h0000)
		else $error("counted while clock off");
	a_unmapped_read: assert property (taken && !wb_we_i && wb_adr_i == 8'h08 |=>
		wb_dat_o == 32'h0)
		else $error("unmapped read not zero");

	c_trigger: cover property (cmdWr && wb_dat_i[2]);
	c_clock_on: cover property ($rose(counterClockOn));
	c_load_stop: cover property ($fell(counterClockOn) && !$past(cmdWr));
endmodule : tcc_channel_asserts

bind tcc_channel tcc_channel_asserts chk_u (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .counterValue,
	.counterClockOn);

// *** testbench/tcc_channel_tb.sv ***
// Self-checking bench for the timer channel clock front end
`timescale 1ns/1ns
module tcc_channel_tb;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        wbCyc = 1'b0;
	logic        wbStb = 1'b0;
	logic        wbWe = 1'b0;
	logic [7:0]  wbAdr = 8'h00;
	logic [31:0] wbDatI = 32'h0;
	logic [3:0]  wbSel = 4'h0;
	logic [3:0]  selMask = 4'hf;
	logic [31:0] wbDatO;
	logic        wbAck;
	logic [2:0]  clkPin;
	logic [2:0]  ioA;
	logic        ioB = 1'b0;
	logic        run = 1'b0;
	logic        lvl = 1'b0;
	logic [2:0]  src = 3'h7;
	logic [15:0] cv;
	logic        on;
	logic [31:0] rdata;
	int          n_fail = 0;
	int          compares = 0;
	int          cycles = 0;
	int          sh[5] = '{1, 3, 5, 7, 10};
	int          tab[3][4] = '{'{0, 0, 4, 5}, '{1, 1, 3, 5}, '{2, 2, 3, 4}};

	tcc_channel dut_u (.sys_clk, .sys_rst, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .clkInputPin(clkPin), .ioAPin(ioA),
		.ioBPin(ioB), .counterValue(cv), .counterClockOn(on));
	tcc_pins_model pins_u (.sys_clk, .run, .lvl, .src, .clkInputPin(clkPin), .ioAPin(ioA));

	always #10 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic final_report();
		$display("compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	function automatic logic [31:0] b(input logic x);
		return {31'h0, x};
	endfunction : b

	task automatic rng(input int lo, input int hi);
		check(b(cv >= lo && cv <= hi), 32'h1);
	endtask : rng

	task automatic w(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : w

	// Classic single cycle: hold until ack, then release for one cycle
	task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
		int n;
		n = 0;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbSel <= selMask;
		wbDatI <= d;
		@(posedge sys_clk);
		while (wbAck !== 1'b1 && n < 20) begin
			n++;
			@(posedge sys_clk);
		end
		if (n == 20)
			check(b(wbAck), 32'h1);
		rdata = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge sys_clk);
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(a, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		wb(a, 1'b0, 32'h0);
	endtask : rd

	initial begin
		w(8);
		sys_rst <= 1'b0;
		w(1);
		rd(8'h04);
		check(rdata, 32'h0);
		rd(8'hc4);
		check(rdata, 32'h0);
		check(b(on), 32'h0);
		wr(8'h04, 32'hffff_ffff);
		rd(8'h04);
		check(rdata, tcc_pkg::MODE_WRITE_MASK);
		wr(8'h04, 32'h0);
		rd(8'h08);
		check(rdata, 32'h0);
		$display("test registers done");
		wr(8'h00, 32'h3);
		check(b(on), 32'h0);
		wr(8'h00, 32'h1);
		check(b(on), 32'h1);
		wr(8'h00, 32'h0);
		check(b(on), 32'h1);
		wr(8'h00, 32'h2);
		check(b(on), 32'h0);
		selMask = 4'he;
		wr(8'h00, 32'h1);
		check(b(on), 32'h0);
		selMask = 4'hf;
		wr(8'h00, 32'h4);
		check(b(on), 32'h1);
		rng(0, 2);
		$display("test commands done");
		for (int i = 0; i < 5; i++) begin
			wr(8'h04, 32'(i));
			wr(8'h00, 32'h5);
			w(2048);
			rng((2048 >> sh[i]) - 2, (2048 >> sh[i]) + 2);
		end
		$display("test prescaler done");
		for (int l = 0; l < 3; l++) begin
			for (int c = 0; c < 4; c++) begin
				wr(8'hc4, 32'(c) << (2 * l));
				wr(8'h04, 32'(5 + l));
				src <= 3'(tab[l][c]);
				run <= 1'b1;
				wr(8'h00, 32'h5);
				w(160);
				rng(c == 1 ? 0 : 8, c == 1 ? 0 : 11);
				run <= 1'b0;
			end
		end
		rd(8'hc4);
		check(rdata, 32'h30);
		wr(8'hc4, 32'h0);
		$display("test shared lines done");
		for (int v = 0; v < 2; v++) begin
			src <= 3'h0;
			lvl <= 1'b0;
			wr(8'h04, 32'h5 | (32'(v) << 3));
			wr(8'h00, 32'h5);
			lvl <= 1'b1;
			w(10);
			rng(1 - v, 1 - v);
			lvl <= 1'b0;
			w(10);
			rng(1, 1);
		end
		for (int g = 1; g < 4; g++) begin
			src <= 3'(g - 1);
			lvl <= 1'b0;
			wr(8'h04, 32'(g) << 4);
			wr(8'h00, 32'h5);
			w(40);
			rng(0, 0);
			lvl <= 1'b1;
			w(40);
			rng(16, 21);
		end
		$display("test edge and gate done");
		for (int v = 0; v < 3; v++) begin
			src <= 3'h3;
			lvl <= 1'b0;
			wr(8'h04, 32'h0009_0000 | (32'(v) << 6));
			wr(8'h00, 32'h5);
			lvl <= 1'b1;
			w(10);
			check(b(on), 32'h1);
			rd(8'h14);
			check(b(rdata != 32'h0), 32'h1);
			lvl <= 1'b0;
			w(10);
			check(b(on), b(v == 0));
			rd(8'h20);
			check(b(rdata[tcc_pkg::STAT_CLKON_BIT]), b(v != 2));
			rd(8'h18);
			check(b(rdata != 32'h0), 32'h1);
		end
		$display("test capture done");
		for (int p = 0; p < 2; p++) begin
			ioB <= 1'b0;
			lvl <= 1'b0;
			wr(8'h04, 32'h100 | (32'(p) << 10));
			wr(8'h00, 32'h2);
			if (p == 1)
				lvl <= 1'b1;
			else
				ioB <= 1'b1;
			w(8);
			check(b(on), 32'h1);
		end
		wr(8'h1c, 32'h5);
		rd(8'h1c);
		check(rdata, 32'h5);
		for (int v = 0; v < 2; v++) begin
			wr(8'h04, 32'(v) << 14);
			wr(8'h00, 32'h5);
			w(100);
			rng(v == 1 ? 0 : 45, v == 1 ? 6 : 55);
		end
		$display("test triggers done");
		final_report();
	end
endmodule : tcc_channel_tb
